// ==== hdl/power_mode_controller.sv ====
// Added by the designer: the address map and register access over AXI4-Lite.
`default_nettype none

// What this block does
// - Five power modes: normal, idle, stop, suspend, sleep.
// - Idle bit halts core after instruction ends.
// - Idle keeps registers; peripherals keep running.
// - Enabled interrupt clears idle, core resumes.
// - Interrupt serviced first, then next instruction.
// - Reset ends idle; restart at address zero.
// - Watchdog resets out of idle; disable if unlocked.
// - Stop bit enters stop after instruction ends.
// - Stop halts core and precision oscillator only.
// - Only reset ends stop; restart at zero.
// - Enabled missing clock detector resets out of stop.
// - Suspend gates clock, oscillators off, quick wake.
// - Sleep gates supply; comparator wake needs two-cell.
// - Unit, regulator and clock always battery powered.
module power_mode_controller #(
  parameter int WDOG_CYCLES = pmc_pkg::WDOG_TIMEOUT_CYC,
  parameter int MCD_CYCLES  = pmc_pkg::MCD_TIMEOUT_CYC
) (
  // Clock and reset.
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address and data.
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response.
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address and data.
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Core handshake.
  input  wire logic        instr_done,
  input  wire logic        irq_pending,
  output logic             core_halt,
  output logic             irq_wake,
  // External reset and wake sources.
  input  wire logic        ext_reset_req,
  input  wire logic        rtc_event,
  input  wire logic        port_match,
  input  wire logic        cmp0_rise,
  input  wire logic        rst_pin_fall,
  // Clock, supply and reset controls.
  output logic             sysclk_gate,
  output logic             precision_osc_en,
  output logic             lowpower_osc_en,
  output logic             supply_gate,
  output logic             core_reset,
  output logic [15:0]      fetch_addr,
  output logic [2:0]       power_mode
);

  initial
  begin
    if (WDOG_CYCLES < 2 || MCD_CYCLES < 2)
      $error("power_mode_controller: timeouts must be at least 2 cycles");
  end

  // Software-visible state.
  logic [3:0]  power_control_q;
  logic [4:0]  wake_cfg_q;
  logic [1:0]  wdog_ctrl_q;
  logic [1:0]  reset_cause_q;
  logic        armed_q;
  pmc_pkg::power_mode_e mode_q;

  // Internal events.
  logic        wdog_expired;
  logic        mcd_expired;
  logic        any_reset;
  logic        wake_hit;
  logic        wr_go;
  logic        rd_go;
  logic [31:0] rd_word;
  logic        aw_hold_q;
  logic        w_hold_q;
  logic [7:0]  aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;

  // Watchdog runs whenever enabled; it or an external reset request can pull the part out of idle by reset.
  timeout_counter #(.LIMIT(WDOG_CYCLES)) u_wdog (
    .aclk    (aclk),
    .aresetn (aresetn),
    .run     (wdog_ctrl_q[pmc_pkg::WDOG_EN_BIT]),
    .kick    (wr_go && aw_addr_q == pmc_pkg::ADDR_WATCHDOG_CTRL),
    .expired (wdog_expired)
  );

  // The clock-detector timeout is modelled as a count that runs while stop holds the clock.
  logic mcd_unused;
  assign mcd_unused = 1'b0;
  logic mcd_run;
  assign mcd_run = wake_cfg_q[pmc_pkg::MCD_ENABLE_BIT] && mode_q == pmc_pkg::MODE_STOP;
  timeout_counter #(.LIMIT(MCD_CYCLES)) u_mcd (
    .aclk    (aclk),
    .aresetn (aresetn),
    .run     (mcd_run),
    .kick    (mcd_unused),
    .expired (mcd_expired)
  );

  // Every internal or external reset source restarts the part.
  assign any_reset = ext_reset_req || wdog_expired || mcd_expired;

  // Suspend and sleep wake sources; comparator counts in suspend, and in sleep only when two-cell is set.
  always_comb
  begin
    wake_hit = rst_pin_fall;
    if (wake_cfg_q[pmc_pkg::WAKE_RTC_BIT] && rtc_event)
      wake_hit = 1'b1;
    if (wake_cfg_q[pmc_pkg::WAKE_PORT_BIT] && port_match)
      wake_hit = 1'b1;
    if (wake_cfg_q[pmc_pkg::WAKE_CMP_BIT] && cmp0_rise &&
        (mode_q != pmc_pkg::MODE_SLEEP || wake_cfg_q[pmc_pkg::TWO_CELL_BIT]))
      wake_hit = 1'b1;
  end

  // Write address and data may come in either order; each is held until both are in.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_q <= 1'b0;
      aw_addr_q <= 8'h00;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_hold_q <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
    end
    else if (wr_go)
      aw_hold_q <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_hold_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_hold_q <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end
    else if (wr_go)
      w_hold_q <= 1'b0;
  end

  assign wr_go = aw_hold_q && w_hold_q && !s_axi_bvalid;

  // Ready is registered; a channel is refused while its item waits for its partner.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end
    else
    begin
      s_axi_awready <= !aw_hold_q && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready  <= !w_hold_q && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
    end
  end

  // Write response; unmapped or read-only offsets answer with a slave error.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= pmc_pkg::RESP_OKAY;
    end
    else if (wr_go)
    begin
      s_axi_bvalid <= 1'b1;
      case (aw_addr_q)
        pmc_pkg::ADDR_POWER_CONTROL,
        pmc_pkg::ADDR_WAKE_CONFIG,
        pmc_pkg::ADDR_WATCHDOG_CTRL: s_axi_bresp <= pmc_pkg::RESP_OKAY;
        default:                     s_axi_bresp <= pmc_pkg::RESP_SLVERR;
      endcase
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // Mode select bits: written by the core, cleared by interrupt wake, suspend wake or reset.
  always_ff @(posedge aclk)
  begin
    if (!aresetn || any_reset)
      power_control_q <= pmc_pkg::POWER_CONTROL_RST;
    else if (wr_go && aw_addr_q == pmc_pkg::ADDR_POWER_CONTROL && w_strb_q[0])
      power_control_q <= w_data_q[3:0];
    else if (mode_q == pmc_pkg::MODE_IDLE && irq_pending)
      power_control_q[pmc_pkg::IDLE_BIT] <= 1'b0;
    else if ((mode_q == pmc_pkg::MODE_SUSPEND || mode_q == pmc_pkg::MODE_SLEEP) && wake_hit)
    begin
      power_control_q[pmc_pkg::SUSPEND_BIT] <= 1'b0;
      power_control_q[pmc_pkg::SLEEP_BIT]   <= 1'b0;
    end
  end

  // A selection takes effect only once the instruction that wrote it retires.
  always_ff @(posedge aclk)
  begin
    if (!aresetn || any_reset)
      armed_q <= 1'b0;
    else if (wr_go && aw_addr_q == pmc_pkg::ADDR_POWER_CONTROL && w_strb_q[0])
      armed_q <= |w_data_q[3:0];
    else if (instr_done)
      armed_q <= 1'b0;
  end

  // Wake configuration; wake enables are kept across entries until rewritten.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      wake_cfg_q <= pmc_pkg::WAKE_CONFIG_RST;
    else if (wr_go && aw_addr_q == pmc_pkg::ADDR_WAKE_CONFIG && w_strb_q[0])
      wake_cfg_q <= w_data_q[4:0];
  end

  // Once locked, the watchdog enable can no longer be cleared until reset.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      wdog_ctrl_q <= pmc_pkg::WATCHDOG_RST;
    else if (wr_go && aw_addr_q == pmc_pkg::ADDR_WATCHDOG_CTRL && w_strb_q[0])
    begin
      wdog_ctrl_q[pmc_pkg::WDOG_LOCK_BIT] <= wdog_ctrl_q[pmc_pkg::WDOG_LOCK_BIT] |
                                             w_data_q[pmc_pkg::WDOG_LOCK_BIT];
      if (!wdog_ctrl_q[pmc_pkg::WDOG_LOCK_BIT])
        wdog_ctrl_q[pmc_pkg::WDOG_EN_BIT] <= w_data_q[pmc_pkg::WDOG_EN_BIT];
    end
  end

  // Last reset cause survives the reset it reports.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      reset_cause_q <= pmc_pkg::CAUSE_PIN;
    else if (wdog_expired)
      reset_cause_q <= pmc_pkg::CAUSE_WDOG;
    else if (mcd_expired)
      reset_cause_q <= pmc_pkg::CAUSE_MCD;
    else if (ext_reset_req)
      reset_cause_q <= pmc_pkg::CAUSE_INTRN;
  end

  // Mode state machine.
  always_ff @(posedge aclk)
  begin
    if (!aresetn || any_reset)
      mode_q <= pmc_pkg::MODE_NORMAL;
    else
    begin
      case (mode_q)
        pmc_pkg::MODE_NORMAL:
          if (armed_q && instr_done)
          begin
            if (power_control_q[pmc_pkg::STOP_BIT])
              mode_q <= pmc_pkg::MODE_STOP;
            else if (power_control_q[pmc_pkg::IDLE_BIT])
              mode_q <= pmc_pkg::MODE_IDLE;
            else if (power_control_q[pmc_pkg::SLEEP_BIT])
              mode_q <= pmc_pkg::MODE_SLEEP;
            else if (power_control_q[pmc_pkg::SUSPEND_BIT])
              mode_q <= pmc_pkg::MODE_SUSPEND;
          end
        pmc_pkg::MODE_IDLE:
          if (irq_pending)
            mode_q <= pmc_pkg::MODE_NORMAL;
        pmc_pkg::MODE_STOP:
          mode_q <= pmc_pkg::MODE_STOP;
        pmc_pkg::MODE_SUSPEND,
        pmc_pkg::MODE_SLEEP:
          if (wake_hit)
            mode_q <= pmc_pkg::MODE_NORMAL;
        default:
          mode_q <= pmc_pkg::MODE_NORMAL;
      endcase
    end
  end

  // Outputs to core, clocks and supplies, all registered.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      core_halt        <= 1'b0;
      irq_wake         <= 1'b0;
      sysclk_gate      <= 1'b0;
      precision_osc_en <= 1'b1;
      lowpower_osc_en  <= 1'b1;
      supply_gate      <= 1'b0;
      power_mode       <= pmc_pkg::MODE_NORMAL;
    end
    else
    begin
      // Idle only halts the core; peripherals keep their clock and state.
      core_halt        <= mode_q != pmc_pkg::MODE_NORMAL;
      irq_wake         <= mode_q == pmc_pkg::MODE_IDLE && irq_pending;
      sysclk_gate      <= mode_q == pmc_pkg::MODE_SUSPEND || mode_q == pmc_pkg::MODE_SLEEP;
      precision_osc_en <= mode_q == pmc_pkg::MODE_NORMAL || mode_q == pmc_pkg::MODE_IDLE;
      // The low power oscillator is left alone by stop, only suspend and sleep kill it.
      lowpower_osc_en  <= !(mode_q == pmc_pkg::MODE_SUSPEND || mode_q == pmc_pkg::MODE_SLEEP);
      // This unit itself stays on battery; only the core domain is gated.
      supply_gate      <= mode_q == pmc_pkg::MODE_SLEEP;
      power_mode       <= mode_q;
    end
  end

  // Core reset and restart address on every reset source.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      core_reset <= 1'b1;
      fetch_addr <= pmc_pkg::RESET_VECTOR;
    end
    else
    begin
      core_reset <= any_reset;
      fetch_addr <= pmc_pkg::RESET_VECTOR;
    end
  end

  // Read mux.
  always_comb
  begin
    rd_word = 32'h0000_0000;
    case (s_axi_araddr)
      pmc_pkg::ADDR_POWER_CONTROL: rd_word[3:0] = power_control_q;
      pmc_pkg::ADDR_WAKE_CONFIG:   rd_word[4:0] = wake_cfg_q;
      pmc_pkg::ADDR_WATCHDOG_CTRL: rd_word[1:0] = wdog_ctrl_q;
      pmc_pkg::ADDR_STATUS:        rd_word[2:0] = mode_q;
      pmc_pkg::ADDR_RESET_CAUSE:   rd_word[1:0] = reset_cause_q;
      default:                     rd_word = 32'h0000_0000;
    endcase
  end

  assign rd_go = s_axi_arvalid && s_axi_arready;

  // Read channel: one read at a time, answered the cycle after address is taken.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= pmc_pkg::RESP_OKAY;
    end
    else if (rd_go)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_word;
      s_axi_rresp   <= (s_axi_araddr <= pmc_pkg::ADDR_RESET_CAUSE && s_axi_araddr[1:0] == 2'b00) ?
                       pmc_pkg::RESP_OKAY : pmc_pkg::RESP_SLVERR;
    end
    else if (s_axi_rvalid)
    begin
      if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
    else
      s_axi_arready <= 1'b1;
  end

endmodule : power_mode_controller

`default_nettype wire

// ==== hdl/pmc_pkg.sv ====
`default_nettype none

package pmc_pkg;

  // Byte addresses of the registers on the AXI4-Lite slave.
  localparam logic [7:0] ADDR_POWER_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_WAKE_CONFIG   = 8'h04;
  localparam logic [7:0] ADDR_WATCHDOG_CTRL = 8'h08;
  localparam logic [7:0] ADDR_STATUS        = 8'h0C;
  localparam logic [7:0] ADDR_RESET_CAUSE   = 8'h10;

  // Field positions in the power control register.
  localparam int IDLE_BIT    = 0;
  localparam int STOP_BIT    = 1;
  localparam int SUSPEND_BIT = 2;
  localparam int SLEEP_BIT   = 3;

  // Field positions in the wake configuration register.
  localparam int WAKE_RTC_BIT    = 0;
  localparam int WAKE_PORT_BIT   = 1;
  localparam int WAKE_CMP_BIT    = 2;
  localparam int TWO_CELL_BIT    = 3;
  localparam int MCD_ENABLE_BIT  = 4;
  localparam int NUM_WAKE        = 3;

  // Field positions in the watchdog control register.
  localparam int WDOG_EN_BIT   = 0;
  localparam int WDOG_LOCK_BIT = 1;

  // Reset values.
  localparam logic [3:0] POWER_CONTROL_RST = 4'h0;
  localparam logic [4:0] WAKE_CONFIG_RST   = 5'h10;
  localparam logic [1:0] WATCHDOG_RST      = 2'h1;
  localparam logic [15:0] RESET_VECTOR     = 16'h0000;

  // Reset-cause codes.
  localparam logic [1:0] CAUSE_PIN   = 2'h0;
  localparam logic [1:0] CAUSE_WDOG  = 2'h1;
  localparam logic [1:0] CAUSE_MCD   = 2'h2;
  localparam logic [1:0] CAUSE_INTRN = 2'h3;

  // AXI responses.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Timing: watchdog and missing clock detector timeouts.
  localparam int CLK_HZ             = 40_000_000;
  localparam int WDOG_TIMEOUT_US    = 1000;
  localparam int MCD_TIMEOUT_US     = 500;
  localparam int WDOG_TIMEOUT_CYC   = WDOG_TIMEOUT_US * (CLK_HZ / 1_000_000);
  localparam int MCD_TIMEOUT_CYC    = MCD_TIMEOUT_US * (CLK_HZ / 1_000_000);

  // Power modes; five distinct modes are kept.
  typedef enum logic [2:0] {
    MODE_NORMAL  = 3'b000,
    MODE_IDLE    = 3'b001,
    MODE_STOP    = 3'b010,
    MODE_SUSPEND = 3'b011,
    MODE_SLEEP   = 3'b100
  } power_mode_e;

endpackage : pmc_pkg

`default_nettype wire

// ==== hdl/timeout_counter.sv ====
`default_nettype none

// Counts while run is high and pulses expired once on reaching the limit.
module timeout_counter #(
  parameter int LIMIT = 16
) (
  // Clock and reset.
  input  wire logic aclk,
  input  wire logic aresetn,
  // Control.
  input  wire logic run,
  input  wire logic kick,
  // Result.
  output logic      expired
);

  localparam int W = $clog2(LIMIT + 1);

  initial
  begin
    if (LIMIT < 2)
      $error("timeout_counter: LIMIT must be at least 2");
  end

  logic [W-1:0] count_q;

  // A kick or a stopped count restarts from zero so the timeout is always whole.
  always_ff @(posedge aclk)
  begin
    if (!aresetn || kick || !run)
      count_q <= '0;
    else if (count_q != W'(LIMIT))
      count_q <= count_q + W'(1);
  end

  // The pulse is registered so the caller sees a clean one-cycle event.
  always_ff @(posedge aclk)
  begin
    if (!aresetn || kick || !run)
      expired <= 1'b0;
    else
      expired <= (count_q == W'(LIMIT - 1));
  end

endmodule : timeout_counter

`default_nettype wire

// ==== bench/power_mode_controller_monitor.sv ====
`default_nettype none

// Watches the mode outputs against the reset and wake events at the ports.
module power_mode_controller_monitor (
  // Clock and reset.
  input wire logic        aclk,
  input wire logic        aresetn,
  // Events and mode outputs.
  input wire logic        ext_reset_req,
  input wire logic        irq_wake,
  input wire logic        core_halt,
  input wire logic        core_reset,
  input wire logic        precision_osc_en,
  input wire logic        lowpower_osc_en,
  input wire logic        sysclk_gate,
  input wire logic        supply_gate,
  input wire logic [15:0] fetch_addr,
  input wire logic [2:0]  power_mode
);
  timeunit 1ns;
  timeprecision 100ps;

  // One domain, so clock and reset are given once for all properties.
  default clocking mon_cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // Mode code and halt.
  AST_MODE_RANGE: assert property (power_mode <= 3'h4)
    else $error("power mode code out of range");
  AST_HALT_LOW_POWER: assert property ((power_mode != 3'h0) |-> core_halt)
    else $error("core runs outside normal mode");
  // Oscillators and gates; two cycles allow the outputs one cycle of lag on entry.
  AST_IDLE_OSC: assert property ((power_mode == 3'h1)[*2] |-> precision_osc_en && !sysclk_gate)
    else $error("idle stopped clocks");
  AST_STOP_OSC: assert property ((power_mode == 3'h2)[*2] |-> !precision_osc_en && lowpower_osc_en)
    else $error("stop oscillator state wrong");
  AST_SUSPEND_GATE: assert property ((power_mode == 3'h3)[*2] |-> sysclk_gate && !lowpower_osc_en && !supply_gate)
    else $error("suspend gating wrong");
  AST_SLEEP_GATE: assert property ((power_mode == 3'h4)[*2] |-> supply_gate && sysclk_gate && !precision_osc_en)
    else $error("sleep gating wrong");
  // Wake and reset paths.
  AST_IRQ_WAKE: assert property (irq_wake |=> (power_mode == 3'h0))
    else $error("interrupt did not end idle");
  AST_EXT_RESET: assert property (ext_reset_req |-> ##[1:2] core_reset)
    else $error("reset request not passed to core");
  AST_STOP_EXIT: assert property ((power_mode == 3'h2) ##1 (power_mode != 3'h2) |-> core_reset || $past(core_reset))
    else $error("stop left without reset");
  AST_RESET_NORMAL: assert property ($fell(core_reset) |-> (power_mode == 3'h0))
    else $error("mode not normal after reset");
  AST_RESET_VECTOR: assert property (core_reset |-> (fetch_addr == 16'h0000))
    else $error("reset vector not zero");

endmodule : power_mode_controller_monitor

bind power_mode_controller power_mode_controller_monitor power_mode_controller_monitor_i (
  .aclk, .aresetn, .ext_reset_req, .irq_wake, .core_halt, .core_reset, .precision_osc_en,
  .lowpower_osc_en, .sysclk_gate, .supply_gate, .fetch_addr, .power_mode
);

`default_nettype wire

// ==== bench/core_model.sv ====
`default_nettype none

// Behavioural processor core beside the mode controller.
module core_model (
  // Clock and reset.
  input  wire logic aclk,
  input  wire logic aresetn,
  // Handshake with the mode controller.
  input  wire logic core_halt,
  input  wire logic irq_req,
  output logic      instr_done,
  output logic      irq_pending
);
  timeunit 1ns;
  timeprecision 100ps;

  // Retires one instruction every other cycle; a halted core retires none, so a mode
  // write only takes effect as the instruction that made it completes.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      instr_done <= 1'b0;
    else
      instr_done <= !core_halt && !instr_done;
  end

  // The request stays pending until the bench withdraws it, as a real source does.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq_pending <= 1'b0;
    else
      irq_pending <= irq_req;
  end

endmodule : core_model

`default_nettype wire

// ==== bench/power_mode_controller_tb_top.sv ====
`default_nettype none

// Bench top: register bus master, event pulses and one task per scenario.
module power_mode_controller_tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        instr_done, irq_pending, core_halt, irq_wake, core_reset;
  logic        irq_req = 1'b0;
  logic [4:0]  ev = 5'h00;
  logic        sysclk_gate, precision_osc_en, lowpower_osc_en, supply_gate;
  logic [15:0] fetch_addr;
  logic [2:0]  power_mode;
  int          fails = 0;
  int          compares = 0;

  // The 40 MHz system clock.
  initial
  begin
    forever #12.5 aclk = ~aclk;
  end

  // Short timeouts keep the watchdog and detector scenarios brief.
  power_mode_controller #(.WDOG_CYCLES(120), .MCD_CYCLES(120)) power_mode_controller_i (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .instr_done, .irq_pending, .core_halt, .irq_wake, .ext_reset_req(ev[4]), .rtc_event(ev[3]),
    .port_match(ev[2]), .cmp0_rise(ev[1]), .rst_pin_fall(ev[0]), .sysclk_gate, .precision_osc_en,
    .lowpower_osc_en, .supply_gate, .core_reset, .fetch_addr, .power_mode
  );
  core_model core_model_i (.aclk, .aresetn, .core_halt, .irq_req, .instr_done, .irq_pending);

  task automatic finish_test();
    $display("compares %0d, fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    compares++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask : chk

  // A wait that used up its bound ends the run.
  task automatic tmo(input int n);
    if (n >= 400)
    begin
      fails++;
      finish_test();
    end
  endtask : tmo

  // Address and data are offered together and each is released once taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      n++;
    end while (!s_axi_bvalid && n < 400);
    tmo(n);
    chk(s_axi_bresp, er, "write response");
  endtask : wr

  // Ready is left high between transfers, so it is never lowered and raised in one time step.
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er, input string msg);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      n++;
    end while (!s_axi_rvalid && n < 400);
    tmo(n);
    chk(s_axi_rresp, er, msg);
    chk(s_axi_rdata, ed, msg);
  endtask : rd

  task automatic wait_mode(input logic [2:0] m);
    int n;
    n = 0;
    while (power_mode !== m && n < 400)
    begin
      @(posedge aclk);
      n++;
    end
    tmo(n);
  endtask : wait_mode

  // Bit order of ev: reset request, clock event, port match, comparator, reset pin.
  // Two edges follow the pulse, so that a wrongly taken wake is already visible on power_mode.
  task automatic pulse(input int i);
    ev[i] <= 1'b1;
    @(posedge aclk);
    ev <= 5'h00;
    repeat (2) @(posedge aclk);
  endtask : pulse

  task automatic t_reset();
    rd(pmc_pkg::ADDR_WAKE_CONFIG, 32'h0000_0010, pmc_pkg::RESP_OKAY, "wake config reset");
    rd(pmc_pkg::ADDR_WATCHDOG_CTRL, 32'h0000_0001, pmc_pkg::RESP_OKAY, "watchdog reset");
    rd(8'h40, 32'h0000_0000, pmc_pkg::RESP_SLVERR, "unmapped read");
    wr(pmc_pkg::ADDR_STATUS, 32'h0000_0001, pmc_pkg::RESP_SLVERR);
    chk(power_mode, 3'h0, "mode after reset");
    chk(fetch_addr, 16'h0000, "reset vector");
    wr(pmc_pkg::ADDR_WATCHDOG_CTRL, 32'h0000_0000, pmc_pkg::RESP_OKAY);
    $display("reset test done.");
  endtask : t_reset

  task automatic t_idle();
    wr(pmc_pkg::ADDR_POWER_CONTROL, 32'h0000_0001, pmc_pkg::RESP_OKAY);
    wait_mode(pmc_pkg::MODE_IDLE);
    chk(precision_osc_en, 1'b1, "clock kept in idle");
    rd(pmc_pkg::ADDR_STATUS, 32'h0000_0001, pmc_pkg::RESP_OKAY, "status in idle");
    irq_req <= 1'b1;
    wait_mode(pmc_pkg::MODE_NORMAL);
    irq_req <= 1'b0;
    chk(core_reset, 1'b0, "interrupt wake without reset");
    rd(pmc_pkg::ADDR_POWER_CONTROL, 32'h0000_0000, pmc_pkg::RESP_OKAY, "idle bit cleared");
    $display("idle test done.");
  endtask : t_idle

  task automatic t_stop();
    wr(pmc_pkg::ADDR_POWER_CONTROL, 32'h0000_0002, pmc_pkg::RESP_OKAY);
    wait_mode(pmc_pkg::MODE_STOP);
    chk(lowpower_osc_en, 1'b1, "low power clock kept");
    irq_req <= 1'b1;
    repeat (10) @(posedge aclk);
    chk(power_mode, pmc_pkg::MODE_STOP, "interrupt ignored in stop");
    irq_req <= 1'b0;
    pulse(4);
    wait_mode(pmc_pkg::MODE_NORMAL);
    rd(pmc_pkg::ADDR_RESET_CAUSE, 32'h0000_0003, pmc_pkg::RESP_OKAY, "reset cause");
    rd(pmc_pkg::ADDR_POWER_CONTROL, 32'h0000_0000, pmc_pkg::RESP_OKAY, "mode bits cleared");
    // The detector is still enabled, so it alone must end the next stop.
    wr(pmc_pkg::ADDR_POWER_CONTROL, 32'h0000_0002, pmc_pkg::RESP_OKAY);
    wait_mode(pmc_pkg::MODE_STOP);
    wait_mode(pmc_pkg::MODE_NORMAL);
    rd(pmc_pkg::ADDR_RESET_CAUSE, 32'h0000_0002, pmc_pkg::RESP_OKAY, "detector cause");
    $display("stop test done.");
  endtask : t_stop

  task automatic t_wdog();
    wr(pmc_pkg::ADDR_WATCHDOG_CTRL, 32'h0000_0001, pmc_pkg::RESP_OKAY);
    wr(pmc_pkg::ADDR_POWER_CONTROL, 32'h0000_0001, pmc_pkg::RESP_OKAY);
    wait_mode(pmc_pkg::MODE_IDLE);
    wait_mode(pmc_pkg::MODE_NORMAL);
    rd(pmc_pkg::ADDR_RESET_CAUSE, 32'h0000_0001, pmc_pkg::RESP_OKAY, "watchdog cause");
    wr(pmc_pkg::ADDR_WATCHDOG_CTRL, 32'h0000_0000, pmc_pkg::RESP_OKAY);
    $display("watchdog test done.");
  endtask : t_wdog

  task automatic t_low();
    wr(pmc_pkg::ADDR_WAKE_CONFIG, 32'h0000_0001, pmc_pkg::RESP_OKAY);
    wr(pmc_pkg::ADDR_POWER_CONTROL, 32'h0000_0004, pmc_pkg::RESP_OKAY);
    wait_mode(pmc_pkg::MODE_SUSPEND);
    pulse(2);
    chk(power_mode, pmc_pkg::MODE_SUSPEND, "disabled source ignored");
    pulse(3);
    wait_mode(pmc_pkg::MODE_NORMAL);
    chk(core_reset, 1'b0, "suspend resumes in place");
    wr(pmc_pkg::ADDR_WAKE_CONFIG, 32'h0000_0004, pmc_pkg::RESP_OKAY);
    wr(pmc_pkg::ADDR_POWER_CONTROL, 32'h0000_0008, pmc_pkg::RESP_OKAY);
    wait_mode(pmc_pkg::MODE_SLEEP);
    pulse(1);
    chk(power_mode, pmc_pkg::MODE_SLEEP, "comparator ignored in one-cell");
    pulse(0);
    wait_mode(pmc_pkg::MODE_NORMAL);
    wr(pmc_pkg::ADDR_WAKE_CONFIG, 32'h0000_000c, pmc_pkg::RESP_OKAY);
    wr(pmc_pkg::ADDR_POWER_CONTROL, 32'h0000_0008, pmc_pkg::RESP_OKAY);
    wait_mode(pmc_pkg::MODE_SLEEP);
    pulse(1);
    wait_mode(pmc_pkg::MODE_NORMAL);
    $display("low power test done.");
  endtask : t_low

  // Once locked, a write of zero must leave the watchdog enabled.
  task automatic t_lock();
    wr(pmc_pkg::ADDR_WATCHDOG_CTRL, 32'h0000_0003, pmc_pkg::RESP_OKAY);
    wr(pmc_pkg::ADDR_WATCHDOG_CTRL, 32'h0000_0000, pmc_pkg::RESP_OKAY);
    rd(pmc_pkg::ADDR_WATCHDOG_CTRL, 32'h0000_0003, pmc_pkg::RESP_OKAY, "lock keeps enable");
    $display("lock test done.");
  endtask : t_lock

  // Main sequence; the first bus request waits two edges after reset release.
  initial
  begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_reset();
    t_idle();
    t_stop();
    t_wdog();
    t_low();
    t_lock();
    finish_test();
  end

endmodule : power_mode_controller_tb_top

`default_nettype wire
